// File: verilog/pcn_defs.svh
/*
  constants of the change-notify and pin-lock block: register byte
  offsets, field positions, reset values and response codes.
  assumes an AXI4-Lite slave with 8 address bits and 32-bit data.
*/
`ifndef PCN_DEFS_SVH
`define PCN_DEFS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define OFS_NOTIFY_CONTROL     8'h00
`define OFS_PIN_ENABLE         8'h04
`define OFS_EDGE_SELECT        8'h08
`define OFS_MISMATCH_STATUS    8'h0c
`define OFS_EVENT_FLAG         8'h10
`define OFS_PORT_INPUT_VALUE   8'h14
`define OFS_PIN_DIRECTION      8'h18
`define OFS_PIN_SELECT_CONTROL 8'h1c
`define OFS_UNLOCK_KEY         8'h20
`define OFS_INPUT_MAP_SELECT   8'h24
`define OFS_OUTPUT_MAP_SELECT  8'h28
`define OFS_INT_STATUS         8'h2c
`define OFS_INT_CLEAR          8'h30
`define OFS_INT_ENABLE         8'h34

// ****************************************
// fields, keys, reset values
// ****************************************
`define BIT_NOTIFY_ON          15
`define BIT_DETECT_STYLE       11
`define BIT_MAP_WRITE_LOCK     11
`define UNLOCK_KEY_FIRST       8'h55
`define UNLOCK_KEY_SECOND      8'haa
`define RST_DIRECTION          16'hffff
`define RST_INPUT_MAP          32'hffffffff
`define RST_OUTPUT_MAP         32'h00000000
`define PIN_COUNT_SEL          8'h10
`define PERIPH_OUT_COUNT       8'h08
`define RESP_OKAY              2'b00
`define RESP_DECERR            2'b11

`endif

// File: verilog/pcn_pkg.sv
/*
  types of the change-notify and pin-lock block.
  assumes pcn_defs.svh for all numeric constants.
*/
package pcn_pkg;

  typedef enum logic [1:0] {key_idle, key_half, key_armed} key_state_type;

  typedef struct packed {
    logic          awready;
    logic          wready;
    logic          bvalid;
    logic [1:0]    bresp;
    logic          arready;
    logic          rvalid;
    logic [1:0]    rresp;
    logic [31:0]   rdata;
    logic          aw_full;
    logic [7:0]    awaddr;
    logic          w_full;
    logic [31:0]   wdata;
    logic [3:0]    wstrb;
    logic [15:0]   sync1;
    logic [15:0]   sync2;
    logic [15:0]   prev;
    logic [15:0]   last_read;
    logic          notify_on;
    logic          detect_style;
    logic [15:0]   cn_pin_enable;
    logic [15:0]   cn_edge_select;
    logic [15:0]   mismatch_status;
    logic [15:0]   cn_event_flag;
    logic [15:0]   pin_direction;
    logic          map_write_lock;
    key_state_type key_state;
    logic [31:0]   input_map_select;
    logic [31:0]   output_map_select;
    logic          int_status;
    logic          int_enable;
    logic          irq;
    logic          cn_request;
    logic [3:0]    periph_in;
    logic [3:0]    remap_pin_out;
    logic [3:0]    remap_pin_oe;
  } state_type;

endpackage : pcn_pkg

// File: verilog/port_change_notify_pin_lock.sv
/*
  one 16-pin port: change notification (mismatch or edge style, sticky
  flags, request level) and the keyed write lock over four input and
  four output pin mapping fields, all behind an AXI4-Lite slave.
  assumes pins are asynchronous; peripheral and gpio signals, analog
  selects and the bus are on aclk.
  limitation: change detection needs aclk running; there is no clockless wake path.
*/
`timescale 1ns/100ps
`include "pcn_defs.svh"

// Behaviour
// - no notification events unless the port notify on bit 15 is set
// - mismatch style: enabled pin flags any change from its last read value
// - edge style: edge select and enable pair pick none, rise, fall or both
// - per-pin enable and edge select bits, 16 bits each, reset to zero
// - per-pin mismatch status shows change since port was last read
// - edge style sets a sticky per-pin flag on each selected edge
// - event flag stays set until software writes that bit to zero
// - notification requests only come from pins set as inputs
// - detection keeps running without any bus activity or software help
// - remappable peripheral reaches a pin only once mapped to it
// - a mapped peripheral overrides other digital functions on its pin
// - analog function on a pin overrides any mapped peripheral output
// - locked mapping writes answer okay but leave contents unchanged
// - lock is bit 11 of pin select control; one blocks mapping writes
// - lock changes only after keys 0x55 then 0xaa, in one next write
// - lock keeps its value until the next keyed change
// - after reset lock clear, input maps all ones, output maps zero
// - mismatch bits feed events in mismatch style, flags in edge style
module port_change_notify_pin_lock (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic [2:0]  arprot,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic [15:0] pin_in,
  input  wire logic [7:0]  periph_out,
  input  wire logic [3:0]  gpio_out,
  input  wire logic [3:0]  gpio_oe,
  input  wire logic [3:0]  analog_sel,
  output logic [3:0]       periph_in,
  output logic [3:0]       remap_pin_out,
  output logic [3:0]       remap_pin_oe,
  output logic             cn_request,
  output logic             irq
);

  pcn_pkg::state_type state_reg;
  pcn_pkg::state_type state_next;
  pcn_pkg::state_type reset_value;

  // combinational helpers; none of them holds state
  logic [15:0] rise;
  logic [15:0] fall;
  logic [15:0] edge_event;
  logic [15:0] event_source;
  logic [31:0] wmask;
  logic [31:0] wval;
  logic [31:0] cur;
  logic        cur_ok;
  logic [31:0] rd;
  logic        rd_ok;
  logic        do_write;
  logic        do_read;
  logic [3:0]  map_out_next;
  logic [3:0]  map_oe_next;
  logic [3:0]  map_in_next;

  // ****************************************
  // register read mux
  // ****************************************
  // write-only registers read zero; unknown offsets answer with a decode error
  function automatic logic [32:0] read_reg(input pcn_pkg::state_type s, input logic [7:0] addr);
    logic [32:0] r;
    r = {1'b1, 32'h00000000};
    unique case (addr)
      `OFS_NOTIFY_CONTROL: begin
        r[`BIT_NOTIFY_ON]    = s.notify_on;
        r[`BIT_DETECT_STYLE] = s.detect_style;
      end
      `OFS_PIN_ENABLE:         r[15:0] = s.cn_pin_enable;
      `OFS_EDGE_SELECT:        r[15:0] = s.cn_edge_select;
      `OFS_MISMATCH_STATUS:    r[15:0] = s.mismatch_status;
      `OFS_EVENT_FLAG:         r[15:0] = s.cn_event_flag;
      `OFS_PORT_INPUT_VALUE:   r[15:0] = s.sync2;
      `OFS_PIN_DIRECTION:      r[15:0] = s.pin_direction;
      `OFS_PIN_SELECT_CONTROL: r[`BIT_MAP_WRITE_LOCK] = s.map_write_lock;
      `OFS_UNLOCK_KEY:         r = {1'b1, 32'h00000000};
      `OFS_INPUT_MAP_SELECT:   r[31:0] = s.input_map_select;
      `OFS_OUTPUT_MAP_SELECT:  r[31:0] = s.output_map_select;
      `OFS_INT_STATUS:         r[0] = s.int_status;
      `OFS_INT_CLEAR:          r = {1'b1, 32'h00000000};
      `OFS_INT_ENABLE:         r[0] = s.int_enable;
      default:                 r = {1'b0, 32'h00000000};
    endcase
    return r;
  endfunction : read_reg

  // ****************************************
  // reset image
  // ****************************************
  always_comb begin
    // bus slots start open so the first request is taken at once
    reset_value                   = '0;
    reset_value.awready           = 1'b1;
    reset_value.wready            = 1'b1;
    reset_value.arready           = 1'b1;
    reset_value.key_state         = pcn_pkg::key_idle;
    reset_value.pin_direction     = `RST_DIRECTION;
    reset_value.input_map_select  = `RST_INPUT_MAP;
    reset_value.output_map_select = `RST_OUTPUT_MAP;
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    state_next = state_reg;

    // ****************************************
    // pin synchronisers and edge finders
    // ****************************************
    // pins pass two flops; sync1 feeds only sync2
    state_next.sync1 = pin_in;
    state_next.sync2 = state_reg.sync1;
    state_next.prev  = state_reg.sync2;
    rise = state_reg.sync2 & ~state_reg.prev;
    fall = ~state_reg.sync2 & state_reg.prev;

    // ****************************************
    // bus write
    // ****************************************
    // write channel capture, either order
    // each channel holds one item; the slot stays shut until the answer is taken
    if (awvalid && state_reg.awready) begin
      state_next.aw_full = 1'b1;
      state_next.awaddr  = awaddr;
    end
    if (wvalid && state_reg.wready) begin
      state_next.w_full = 1'b1;
      state_next.wdata  = wdata;
      state_next.wstrb  = wstrb;
    end
    if (bready && state_reg.bvalid) begin
      state_next.bvalid = 1'b0;
    end

    // unstrobed lanes keep the current value, so flag writes can skip lanes
    for (int b = 0; b < 4; b++) begin
      wmask[8*b +: 8] = {8{state_reg.wstrb[b]}};
    end
    {cur_ok, cur} = read_reg(state_reg, state_reg.awaddr);
    wval     = (cur & ~wmask) | (state_reg.wdata & wmask);
    do_write = state_reg.aw_full && state_reg.w_full && !state_reg.bvalid;

    if (do_write) begin
      state_next.aw_full = 1'b0;
      state_next.w_full  = 1'b0;
      state_next.bvalid  = 1'b1;
      state_next.bresp   = cur_ok ? `RESP_OKAY : `RESP_DECERR;
      // a key stage survives only into the very next write
      state_next.key_state = pcn_pkg::key_idle;
      unique case (state_reg.awaddr)
        `OFS_NOTIFY_CONTROL: begin
          state_next.notify_on    = wval[`BIT_NOTIFY_ON];
          state_next.detect_style = wval[`BIT_DETECT_STYLE];
        end
        `OFS_PIN_ENABLE:    state_next.cn_pin_enable  = wval[15:0];
        `OFS_EDGE_SELECT:   state_next.cn_edge_select = wval[15:0];
        `OFS_EVENT_FLAG:    state_next.cn_event_flag  = state_reg.cn_event_flag & wval[15:0];
        `OFS_PIN_DIRECTION: state_next.pin_direction  = wval[15:0];
        `OFS_PIN_SELECT_CONTROL: begin
          if (state_reg.key_state == pcn_pkg::key_armed) begin
            state_next.map_write_lock = wval[`BIT_MAP_WRITE_LOCK];
          end
        end
        // a first key again restarts the sequence instead of cancelling it
        // key sequence
        `OFS_UNLOCK_KEY: begin
          if (wval[7:0] == `UNLOCK_KEY_FIRST) begin
            state_next.key_state = pcn_pkg::key_half;
          end else if (wval[7:0] == `UNLOCK_KEY_SECOND && state_reg.key_state == pcn_pkg::key_half) begin
            state_next.key_state = pcn_pkg::key_armed;
          end
        end
        `OFS_INPUT_MAP_SELECT: begin
          if (!state_reg.map_write_lock) begin
            state_next.input_map_select = wval;
          end
        end
        `OFS_OUTPUT_MAP_SELECT: begin
          if (!state_reg.map_write_lock) begin
            state_next.output_map_select = wval;
          end
        end
        `OFS_INT_CLEAR:  state_next.int_status = state_reg.int_status & ~wval[0];
        `OFS_INT_ENABLE: state_next.int_enable = wval[0];
        default: begin
        end
      endcase
    end
    state_next.awready = !state_next.aw_full && !state_next.bvalid;
    state_next.wready  = !state_next.w_full && !state_next.bvalid;

    // ****************************************
    // bus read
    // ****************************************
    // read channel
    // arready stays low until the answer is taken: one read in flight
    {rd_ok, rd} = read_reg(state_reg, araddr);
    do_read     = arvalid && state_reg.arready;
    if (rready && state_reg.rvalid) begin
      state_next.rvalid  = 1'b0;
      state_next.arready = 1'b1;
    end
    if (do_read) begin
      state_next.arready = 1'b0;
      state_next.rvalid  = 1'b1;
      state_next.rdata   = rd;
      state_next.rresp   = rd_ok ? `RESP_OKAY : `RESP_DECERR;
      if (araddr == `OFS_PORT_INPUT_VALUE) begin
        state_next.last_read       = state_reg.sync2;
        state_next.mismatch_status = 16'h0000;
      end
    end

    // ****************************************
    // change detection
    // ****************************************
    // hardware sets come after software clears so a set always wins
    // with notify off nothing is set; flags already set stay for software
    // free running detect
    if (state_reg.notify_on && !state_reg.detect_style) begin
      state_next.mismatch_status = state_next.mismatch_status
                                 | ((state_reg.sync2 ^ state_next.last_read) & state_reg.cn_pin_enable);
    end
    edge_event = (rise & state_reg.cn_pin_enable & ~state_reg.cn_edge_select)
               | (fall & ~state_reg.cn_pin_enable & state_reg.cn_edge_select)
               | ((rise | fall) & state_reg.cn_pin_enable & state_reg.cn_edge_select);
    if (state_reg.notify_on && state_reg.detect_style) begin
      state_next.cn_event_flag = state_next.cn_event_flag | edge_event;
    end

    // ****************************************
    // request and interrupt
    // ****************************************
    // output pins still flag; only the request is held back for them
    // style picks source
    event_source = state_reg.detect_style
                 ? state_next.cn_event_flag & (state_reg.cn_pin_enable | state_reg.cn_edge_select)
                 : state_next.mismatch_status & state_reg.cn_pin_enable;
    state_next.cn_request = state_reg.notify_on && (|(event_source & state_reg.pin_direction));
    // only a rising request sets status, so a clear while it stands sticks
    if (state_next.cn_request && !state_reg.cn_request) begin
      state_next.int_status = 1'b1;
    end
    state_next.irq = state_next.int_status && state_next.int_enable;

    // mapped pins are worked out per slice below and registered here
    state_next.remap_pin_out = map_out_next;
    state_next.remap_pin_oe  = map_oe_next;
    state_next.periph_in     = map_in_next;
  end

  // ****************************************
  // pin mapping, one slice per remappable pin
  // ****************************************
  for (genvar i = 0; i < 4; i++) begin : g_map
    logic [7:0] out_sel;
    logic [7:0] in_sel;
    logic       out_mapped;
    assign out_sel    = state_reg.output_map_select[8*i +: 8];
    assign in_sel     = state_reg.input_map_select[8*i +: 8];
    // the null code and codes past the last peripheral leave the pin to gpio
    assign out_mapped = (out_sel != 8'h00) && (out_sel < `PERIPH_OUT_COUNT);
    assign map_out_next[i] = analog_sel[i] ? 1'b0 : (out_mapped ? periph_out[out_sel[2:0]] : gpio_out[i]);
    assign map_oe_next[i]  = analog_sel[i] ? 1'b0 : (out_mapped || gpio_oe[i]);
    // out of range selections, the reset value among them, read low
    assign map_in_next[i]  = (in_sel < `PIN_COUNT_SEL) ? state_reg.sync2[in_sel[3:0]] : 1'b0;
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge aclk) begin
    // reset reloads the synchronisers too, so a pin high after reset reads as a rise
    if (!aresetn) begin
      state_reg <= reset_value;
    end else begin
      state_reg <= state_next;
    end
  end

  assign awready       = state_reg.awready;
  assign wready        = state_reg.wready;
  assign bvalid        = state_reg.bvalid;
  assign bresp         = state_reg.bresp;
  assign arready       = state_reg.arready;
  assign rvalid        = state_reg.rvalid;
  assign rdata         = state_reg.rdata;
  assign rresp         = state_reg.rresp;
  assign periph_in     = state_reg.periph_in;
  assign remap_pin_out = state_reg.remap_pin_out;
  assign remap_pin_oe  = state_reg.remap_pin_oe;
  assign cn_request    = state_reg.cn_request;
  assign irq           = state_reg.irq;

endmodule : port_change_notify_pin_lock

// File: sim/pcn_props.sv
/*
  bound checks on the bus handshakes and pin outputs of the notify block.
  assumes the ports of port_change_notify_pin_lock and one clock, aclk.
*/
`timescale 1ns/100ps
module pcn_props (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [1:0]  bresp,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata,
  input wire logic [3:0]  analog_sel,
  input wire logic [3:0]  remap_pin_oe,
  input wire logic        cn_request,
  input wire logic        irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence write_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence read_taken;
    arvalid && arready;
  endsequence
  write_answer_a: assert property (write_taken |-> !bvalid ##1 !bvalid ##1 bvalid)
    else $error("write answer not two cycles after handshake");
  bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped or changed");
  slot_closed_a: assert property (bvalid |-> !awready && !wready)
    else $error("write slot open while answer pending");
  bvalid_drop_a: assert property (bvalid && bready |=> !bvalid && awready)
    else $error("write answer not released");
  read_answer_a: assert property (read_taken |=> rvalid && !arready)
    else $error("read answer not one cycle after address");
  rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped or changed");
  analog_wins_a: assert property ((analog_sel != 4'h0) |=> (remap_pin_oe & $past(analog_sel)) == 4'h0)
    else $error("pin driven while analog selected");
  // reset itself is the cause here, so this one is never disabled
  reset_quiet_a: assert property (disable iff (1'b0) !aresetn |=> !cn_request && !irq && !bvalid && !rvalid)
    else $error("outputs active after reset edge");
endmodule : pcn_props

bind port_change_notify_pin_lock pcn_props props (
  .aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid, .bready, .bresp,
  .arvalid, .arready, .rvalid, .rready, .rdata, .analog_sel, .remap_pin_oe, .cn_request, .irq
);

// File: sim/pin_world.sv
/*
  pin side model: pad levels, peripheral outputs, default gpio drive, analog selects.
  assumes the bench calls its tasks from one process.
*/
`timescale 1ns/100ps
module pin_world (
  input  wire logic        aclk,
  output logic      [15:0] pin_in,
  output logic      [7:0]  periph_out,
  output logic      [3:0]  gpio_out,
  output logic      [3:0]  gpio_oe,
  output logic      [3:0]  analog_sel
);
  initial begin
    pin_in = 16'h0000;
    periph_out = 8'h00;
    gpio_out = 4'h0;
    gpio_oe = 4'h0;
    analog_sel = 4'h0;
  end
  task automatic set_pins(input logic [15:0] v);
    @(posedge aclk);
    pin_in <= v;
  endtask : set_pins
  task automatic set_side(input logic [7:0] po, input logic [3:0] go, input logic [3:0] oe, input logic [3:0] an);
    @(posedge aclk);
    periph_out <= po;
    gpio_out <= go;
    gpio_oe <= oe;
    analog_sel <= an;
  endtask : set_side
endmodule : pin_world

// File: sim/tb_port_change_notify_pin_lock.sv
/*
  self-checking bench: reset values, edge and mismatch detection, interrupt, key lock, mapping.
  assumes pin_world on the pin side and pcn_props bound to the design.
*/
`timescale 1ns/100ps
`include "pcn_defs.svh"
module tb_port_change_notify_pin_lock;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, cn_request, irq;
  logic [7:0]  awaddr, araddr, periph_out;
  logic [31:0] wdata, rdata, rd_data;
  logic [3:0]  wstrb, gpio_out, gpio_oe, analog_sel, periph_in, remap_pin_out, remap_pin_oe;
  logic [1:0]  bresp, rresp, wr_resp, rd_resp;
  logic [15:0] pin_in;
  int          failures, check_count, cycles;
  pin_world pw (.aclk, .pin_in, .periph_out, .gpio_out, .gpio_oe, .analog_sel);
  port_change_notify_pin_lock dut (
    .aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .pin_in, .periph_out, .gpio_out, .gpio_oe, .analog_sel, .periph_in, .remap_pin_out,
    .remap_pin_oe, .cn_request, .irq
  );
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  // address and data are offered together and released one by one as taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
    logic aw_on;
    logic w_on;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw_on = 1'b1;
    w_on = 1'b1;
    forever begin
      @(posedge aclk);
      if (aw_on && awready === 1'b1) begin
        awvalid <= 1'b0;
        aw_on = 1'b0;
      end
      if (w_on && wready === 1'b1) begin
        wvalid <= 1'b0;
        w_on = 1'b0;
      end
      if (bvalid === 1'b1) begin
        wr_resp = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        rd_data = rdata;
        rd_resp = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask : rd
  task automatic keyed(input logic [7:0] k1, input logic [7:0] k2, input logic [31:0] v);
    wr(`OFS_UNLOCK_KEY, {24'h0, k1});
    wr(`OFS_UNLOCK_KEY, {24'h0, k2});
    wr(`OFS_PIN_SELECT_CONTROL, v);
  endtask : keyed
  task automatic t_reset;
    logic [7:0]  ra [6] = '{`OFS_NOTIFY_CONTROL, `OFS_PIN_ENABLE, `OFS_EDGE_SELECT, `OFS_EVENT_FLAG,
                            `OFS_PIN_SELECT_CONTROL, `OFS_OUTPUT_MAP_SELECT};
    for (int i = 0; i < 6; i++) begin
      rd(ra[i]);
      check("reset value", rd_data, 32'h0);
    end
    rd(`OFS_INPUT_MAP_SELECT);
    check("input map reset", rd_data, 32'hffffffff);
    wr(`OFS_EDGE_SELECT, 32'h0000a5c3);
    rd(`OFS_EDGE_SELECT);
    check("edge select rw", rd_data, 32'h0000a5c3);
    wr(`OFS_EDGE_SELECT, 32'h00000f0f, 4'h1);
    rd(`OFS_EDGE_SELECT);
    check("strobed lane", rd_data, 32'h0000a50f);
    wr(8'h40, 32'h1);
    check("unmapped write", 32'(wr_resp), 32'h3);
    rd(8'h40);
    check("unmapped read", 32'(rd_resp), 32'h3);
  endtask : t_reset
  // pin i gets enable i[0] and edge select i[1]: none, rise, fall, both
  task automatic t_edges;
    wr(`OFS_PIN_ENABLE, 32'ha);
    wr(`OFS_EDGE_SELECT, 32'hc);
    wr(`OFS_INT_ENABLE, 32'h1);
    wr(`OFS_NOTIFY_CONTROL, 32'h8800);
    pw.set_pins(16'h000f);
    repeat (4) @(posedge aclk);
    check("idle detect", 32'(cn_request), 32'h1);
    rd(`OFS_EVENT_FLAG);
    check("rise flags", rd_data, 32'ha);
    check("request up", 32'(cn_request), 32'h1);
    check("irq up", 32'(irq), 32'h1);
    pw.set_pins(16'h0000);
    repeat (4) @(posedge aclk);
    rd(`OFS_EVENT_FLAG);
    check("fall flags", rd_data, 32'he);
    wr(`OFS_EVENT_FLAG, 32'hfffb);
    rd(`OFS_EVENT_FLAG);
    check("clear one flag", rd_data, 32'ha);
    wr(`OFS_INT_ENABLE, 32'h0);
    check("irq masked", 32'(irq), 32'h0);
    wr(`OFS_INT_ENABLE, 32'h1);
    wr(`OFS_INT_CLEAR, 32'h1);
    rd(`OFS_INT_STATUS);
    check("int cleared", rd_data, 32'h0);
    wr(`OFS_EVENT_FLAG, 32'h0);
    repeat (2) @(posedge aclk);
    check("request down", 32'(cn_request), 32'h0);
  endtask : t_edges
  task automatic t_mismatch;
    wr(`OFS_NOTIFY_CONTROL, 32'h8000);
    wr(`OFS_PIN_ENABLE, 32'h1);
    rd(`OFS_PORT_INPUT_VALUE);
    pw.set_pins(16'h0003);
    repeat (4) @(posedge aclk);
    rd(`OFS_MISMATCH_STATUS);
    check("mismatch set", rd_data & 32'h1, 32'h1);
    check("mismatch request", 32'(cn_request), 32'h1);
    rd(`OFS_PORT_INPUT_VALUE);
    check("port value", rd_data, 32'h3);
    rd(`OFS_MISMATCH_STATUS);
    check("mismatch rebased", rd_data & 32'h1, 32'h0);
    wr(`OFS_PIN_DIRECTION, 32'hfffe);
    pw.set_pins(16'h0000);
    repeat (4) @(posedge aclk);
    check("output pin quiet", 32'(cn_request), 32'h0);
    rd(`OFS_PORT_INPUT_VALUE);
    wr(`OFS_NOTIFY_CONTROL, 32'h0);
    wr(`OFS_PIN_DIRECTION, 32'hffff);
    pw.set_pins(16'h0001);
    repeat (4) @(posedge aclk);
    rd(`OFS_MISMATCH_STATUS);
    check("off no status", rd_data & 32'h1, 32'h0);
    check("off no request", 32'(cn_request), 32'h0);
  endtask : t_mismatch
  task automatic t_lock;
    wr(`OFS_INPUT_MAP_SELECT, 32'h00000005);
    wr(`OFS_OUTPUT_MAP_SELECT, 32'h00000001);
    pw.set_side(8'h02, 4'h0, 4'hf, 4'h0);
    pw.set_pins(16'h0020);
    repeat (4) @(posedge aclk);
    check("mapped input", 32'(periph_in[0]), 32'h1);
    check("mapped drive", 32'({remap_pin_oe[0], remap_pin_out[0]}), 32'h3);
    pw.set_side(8'h02, 4'h0, 4'hf, 4'h1);
    repeat (3) @(posedge aclk);
    check("analog wins", 32'(remap_pin_oe[0]), 32'h0);
    pw.set_side(8'h00, 4'h2, 4'h2, 4'h1);
    repeat (3) @(posedge aclk);
    check("gpio drive", 32'(remap_pin_out[1]), 32'h1);
    check("gpio enables", 32'(remap_pin_oe), 32'h2);
    keyed(`UNLOCK_KEY_FIRST, `UNLOCK_KEY_SECOND, 32'h800);
    rd(`OFS_PIN_SELECT_CONTROL);
    check("locked", rd_data, 32'h800);
    wr(`OFS_OUTPUT_MAP_SELECT, 32'h0);
    check("locked write okay", 32'(wr_resp), 32'h0);
    rd(`OFS_OUTPUT_MAP_SELECT);
    check("locked map kept", rd_data, 32'h1);
    keyed(`UNLOCK_KEY_SECOND, `UNLOCK_KEY_FIRST, 32'h0);
    rd(`OFS_PIN_SELECT_CONTROL);
    check("wrong key order", rd_data, 32'h800);
    keyed(`UNLOCK_KEY_FIRST, `UNLOCK_KEY_SECOND, 32'h0);
    wr(`OFS_OUTPUT_MAP_SELECT, 32'h3);
    wr(`OFS_OUTPUT_MAP_SELECT, 32'h2);
    rd(`OFS_OUTPUT_MAP_SELECT);
    check("unlocked writes", rd_data, 32'h2);
  endtask : t_lock
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      tally_and_finish();
    end
  end
  initial begin
    aresetn = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hf;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_edges();
    t_mismatch();
    t_lock();
    tally_and_finish();
  end
endmodule : tb_port_change_notify_pin_lock
